//--- design/tfc_timer_map.vh
// Register offsets, field positions, reset values and codes of the timer flip-flop control slice
`ifndef TFC_TIMER_MAP_VH
`define TFC_TIMER_MAP_VH

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define TFC_OFS_RUN      12'h000
`define TFC_OFS_MODE     12'h004
`define TFC_OFS_FFCR     12'h008
`define TFC_OFS_STATUS   12'h00c
`define TFC_OFS_MASK     12'h010
`define TFC_OFS_CMP0     12'h014
`define TFC_OFS_CMP1     12'h018
`define TFC_OFS_CAP0     12'h01c
`define TFC_OFS_CAP1     12'h020
`define TFC_OFS_COUNT    12'h024

// ****************************************************************************
// Field positions
// ****************************************************************************
`define TFC_MODE_CLK_HI  2
`define TFC_MODE_CLK_LO  0
`define TFC_MODE_CLE     3
`define TFC_MODE_SWCAP   6
`define TFC_FF_CMD_HI    1
`define TFC_FF_CMD_LO    0
`define TFC_FF_TM0       2
`define TFC_FF_TM1       3
`define TFC_FF_TC0       4
`define TFC_FF_TC1       5
`define TFC_ST_M0        0
`define TFC_ST_M1        1
`define TFC_ST_OVF       2

// ****************************************************************************
// Reset values and codes
// ****************************************************************************
`define TFC_FF_TOG_RST   4'h0
`define TFC_FF_CONST     32'h000000c3
`define TFC_CMD_INVERT   2'h0
`define TFC_CMD_SET      2'h1
`define TFC_CMD_CLEAR    2'h2
`define TFC_CLK_PIN      3'h0
`define TFC_CLK_DIV1     3'h1
`define TFC_CLK_DIV4     3'h2
`define TFC_CLK_DIV16    3'h3
`define TFC_CLK_DIV32    3'h4
`define TFC_CLK_DIV64    3'h5
`define TFC_CLK_DIV128   3'h6
`define TFC_CNT_MAX      16'hffff

`endif

//--- design/tfc_timer.v
// Timer channel with clock select, match clear, capture, output flop and AHB-Lite registers
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tfc_timer_map.vh"

module tfc_timer
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        external_count_pin,
  input  wire        capture1_pin,
  output reg         timer_output_flop,
  output reg         irq
);

  // ****************************************************************************
  // State
  // ****************************************************************************
  reg  [15:0] count_r;
  reg  [15:0] compare_reg0_r;
  reg  [15:0] compare_reg1_r;
  reg  [15:0] capture_reg0_r;
  reg  [15:0] capture_reg1_r;
  reg  [7:0]  prescale_r;
  reg         run_r;
  reg  [2:0]  count_clock_select_r;
  reg         match1_clear_enable_r;
  reg  [3:0]  toggle_en_r;
  reg  [2:0]  event_status_r;
  reg  [2:0]  event_mask_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [11:0] addr_r;

  reg  [2:0]  status_nxt;
  reg         flop_nxt;
  reg  [15:0] count_nxt;
  reg  [31:0] rdata_nxt;
  reg         tap;

  // Word decode shared by the write and read strobes below
  function reg_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  wire        addr_phase = hsel & hready & htrans[1];
  wire        wr_mode    = wr_pend_r & reg_hit(addr_r, `TFC_OFS_MODE);
  wire        wr_ffcr    = wr_pend_r & reg_hit(addr_r, `TFC_OFS_FFCR);
  wire        wr_status  = wr_pend_r & reg_hit(addr_r, `TFC_OFS_STATUS);
  wire        rd_status  = rd_pend_r & reg_hit(addr_r, `TFC_OFS_STATUS);
  wire [1:0]  pin_in     = {capture1_pin, external_count_pin};
  wire [1:0]  pin_rise;

  // ****************************************************************************
  // Count enable
  // ****************************************************************************
  function is_tap;
    input [2:0] sel;
    input [7:0] pre;
    begin
      case (sel)
        `TFC_CLK_DIV1:   is_tap = 1'b1;
        `TFC_CLK_DIV4:   is_tap = &pre[1:0];
        `TFC_CLK_DIV16:  is_tap = &pre[3:0];
        `TFC_CLK_DIV32:  is_tap = &pre[4:0];
        `TFC_CLK_DIV64:  is_tap = &pre[5:0];
        `TFC_CLK_DIV128: is_tap = &pre[6:0];
        default:         is_tap = &pre[7:0];
      endcase
    end
  endfunction

  // ****************************************************************************
  // Pin synchronisers
  // ****************************************************************************
  // Two stages settle each pin; the third only holds the previous settled level
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_pin_sync
      reg [2:0] sync_r;
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          sync_r <= 3'h0;
        else
          sync_r <= {sync_r[1:0], pin_in[gi]};
      end
      assign pin_rise[gi] = sync_r[1] & ~sync_r[2];
    end
  endgenerate

  wire pin_edge  = pin_rise[0];
  wire cap1_edge = pin_rise[1];

  always @*
  begin
    if (count_clock_select_r == `TFC_CLK_PIN)
      tap = pin_edge;
    else
      tap = is_tap(count_clock_select_r, prescale_r);
  end

  wire tick     = run_r & tap;
  wire match0   = tick & (count_r == compare_reg0_r);
  wire match1   = tick & (count_r == compare_reg1_r);
  wire overflow = tick & (count_r == `TFC_CNT_MAX);
  wire swcap    = wr_mode & ~hwdata[`TFC_MODE_SWCAP];
  wire cap1     = cap1_edge;

  // ****************************************************************************
  // Next values
  // ****************************************************************************
  always @*
  begin
    count_nxt = count_r;
    if (match1 & match1_clear_enable_r)
      count_nxt = 16'h0000;
    else if (tick)
      count_nxt = count_r + 16'h0001;
  end

  always @*
  begin
    flop_nxt = timer_output_flop
             ^ (match0 & toggle_en_r[0])
             ^ (match1 & toggle_en_r[1])
             ^ (swcap  & toggle_en_r[2])
             ^ (cap1   & toggle_en_r[3]);
    if (wr_ffcr)
    begin
      case (hwdata[`TFC_FF_CMD_HI:`TFC_FF_CMD_LO])
        `TFC_CMD_INVERT: flop_nxt = ~timer_output_flop;
        `TFC_CMD_SET:    flop_nxt = 1'b1;
        `TFC_CMD_CLEAR:  flop_nxt = 1'b0;
        default:         flop_nxt = flop_nxt;
      endcase
    end
  end

  // Set wins over read clear and write-one clear
  always @*
  begin
    status_nxt = event_status_r;
    if (rd_status)
      status_nxt = 3'h0;
    if (wr_status)
      status_nxt = status_nxt & ~hwdata[2:0];
    status_nxt[`TFC_ST_M0]  = status_nxt[`TFC_ST_M0]  | match0;
    status_nxt[`TFC_ST_M1]  = status_nxt[`TFC_ST_M1]  | match1;
    status_nxt[`TFC_ST_OVF] = status_nxt[`TFC_ST_OVF] | overflow;
  end

  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (addr_r == `TFC_OFS_RUN)
      rdata_nxt[0] = run_r;
    else if (addr_r == `TFC_OFS_MODE)
    begin
      rdata_nxt[`TFC_MODE_SWCAP] = 1'b1;
      rdata_nxt[`TFC_MODE_CLE]   = match1_clear_enable_r;
      rdata_nxt[2:0]             = count_clock_select_r;
    end
    else if (addr_r == `TFC_OFS_FFCR)
      rdata_nxt = `TFC_FF_CONST | {26'h0000000, toggle_en_r, 2'h0};
    else if (addr_r == `TFC_OFS_STATUS)
      rdata_nxt[2:0] = event_status_r;
    else if (addr_r == `TFC_OFS_MASK)
      rdata_nxt[2:0] = event_mask_r;
    else if (addr_r == `TFC_OFS_CMP0)
      rdata_nxt[15:0] = compare_reg0_r;
    else if (addr_r == `TFC_OFS_CMP1)
      rdata_nxt[15:0] = compare_reg1_r;
    else if (addr_r == `TFC_OFS_CAP0)
      rdata_nxt[15:0] = capture_reg0_r;
    else if (addr_r == `TFC_OFS_CAP1)
      rdata_nxt[15:0] = capture_reg1_r;
    else if (addr_r == `TFC_OFS_COUNT)
      rdata_nxt[15:0] = count_r;
  end

  // ****************************************************************************
  // Bus slave
  // ****************************************************************************
  // Reads take one wait state so a write just before is already visible
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp     <= 1'b0;
      wr_pend_r <= addr_phase & hwrite;
      rd_pend_r <= addr_phase & ~hwrite;
      if (addr_phase)
        addr_r <= {haddr[11:2], 2'b00};
      if (addr_phase & ~hwrite)
        hreadyout <= 1'b0;
      else if (rd_pend_r)
      begin
        hreadyout <= 1'b1;
        hrdata    <= rdata_nxt;
      end
    end
  end

  // ****************************************************************************
  // Registers and timer
  // ****************************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r                 <= 1'b0;
      count_clock_select_r  <= `TFC_CLK_PIN;
      match1_clear_enable_r <= 1'b0;
      toggle_en_r           <= `TFC_FF_TOG_RST;
      event_status_r        <= 3'h0;
      event_mask_r          <= 3'h0;
      compare_reg0_r        <= 16'h0000;
      compare_reg1_r        <= 16'h0000;
      capture_reg0_r        <= 16'h0000;
      capture_reg1_r        <= 16'h0000;
      count_r               <= 16'h0000;
      prescale_r            <= 8'h00;
      timer_output_flop     <= 1'b0;
      irq                   <= 1'b0;
    end
    else
    begin
      prescale_r        <= run_r ? prescale_r + 8'h01 : 8'h00;
      count_r           <= count_nxt;
      event_status_r    <= status_nxt;
      timer_output_flop <= flop_nxt;
      irq               <= |(status_nxt & event_mask_r);
      if (swcap)
        capture_reg0_r <= count_r;
      if (cap1)
        capture_reg1_r <= count_r;
      if (wr_pend_r)
      begin
        if (addr_r == `TFC_OFS_RUN)
          run_r <= hwdata[0];
        else if (addr_r == `TFC_OFS_MODE)
        begin
          // Changes while running are the software's hazard
          match1_clear_enable_r <= hwdata[`TFC_MODE_CLE];
          count_clock_select_r  <= hwdata[`TFC_MODE_CLK_HI:`TFC_MODE_CLK_LO];
        end
        else if (addr_r == `TFC_OFS_FFCR)
          toggle_en_r <= hwdata[`TFC_FF_TC1:`TFC_FF_TM0];
        else if (addr_r == `TFC_OFS_MASK)
          event_mask_r <= hwdata[2:0];
        else if (addr_r == `TFC_OFS_CMP0)
          compare_reg0_r <= hwdata[15:0];
        else if (addr_r == `TFC_OFS_CMP1)
          compare_reg1_r <= hwdata[15:0];
        else if (addr_r == `TFC_OFS_COUNT)
          count_r <= hwdata[15:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/tfc_timer_properties.sv
// Bus timing and output flop checks for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tfc_timer_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        external_count_pin,
  input wire logic        capture1_pin,
  input wire logic        timer_output_flop,
  input wire logic        irq
);
  wire        tk = hsel && hready && htrans[1];
  logic       wr_r;
  logic       rd_r;
  logic [9:0] ad_r;
  // Address phase remembered for the data phase
  always_ff @(posedge hclk)
  begin
    wr_r <= tk && hwrite;
    rd_r <= tk && !hwrite;
    ad_r <= tk ? haddr[11:2] : ad_r;
  end
  wire ff = wr_r && ad_r == 10'h2;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (!hresp) else $error("bad response");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  a_read_onewait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_flop_set: assert property (ff && hwdata[1:0] == 2'h1 |=> timer_output_flop)
    else $error("flop not set");
  a_flop_clear: assert property (ff && hwdata[1:0] == 2'h2 |=> !timer_output_flop)
    else $error("flop not cleared");
  a_flop_invert: assert property (
    ff && hwdata[1:0] == 2'h0 |=> timer_output_flop != $past(timer_output_flop))
    else $error("flop not inverted");
  a_ffcr_fixed: assert property (
    rd_r && ad_r == 10'h2 |=> hrdata[1:0] == 2'h3 && hrdata[7:6] == 2'h3 && hrdata[31:8] == 24'h0)
    else $error("control read wrong");
  a_mode_fixed: assert property (
    rd_r && ad_r == 10'h1 |=> hrdata[6] && hrdata[5:4] == 2'h0 && hrdata[31:7] == 25'h0)
    else $error("mode read wrong");
  a_status_high: assert property (rd_r && ad_r == 10'h3 |=> hrdata[31:3] == 29'h0)
    else $error("status high bits set");
endmodule
bind tfc_timer tfc_timer_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .external_count_pin, .capture1_pin,
  .timer_output_flop, .irq);
`default_nettype wire

//--- tb/tb_tfc_timer.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
`include "tfc_timer_map.vh"
module tb_tfc_timer;
  localparam logic [31:0] all = 32'hffffffff;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ext_pin = 1'b0;
  logic        cap_pin = 1'b0;
  logic        pend = 1'b0;
  logic [31:0] rv;
  logic [63:0] exq[$];
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, tof, irq;
  int          n_fail = 0, n_checks = 0, cyc = 0, dv;
  always #2 hclk = ~hclk;
  tfc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(ext_pin),
    .capture1_pin(cap_pin), .timer_output_flop(tof), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic fail(input string s);
    n_fail++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_rdy;
    logic r;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end
    while (!r);
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exq.push_back({m, e});
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic run(input int n);
    wr(`TFC_OFS_RUN, 32'h1);
    repeat (n) @(posedge hclk);
    wr(`TFC_OFS_RUN, 32'h0);
  endtask
  task automatic chk(input logic use_irq, input logic e);
    #1;
    n_checks++;
    if ((use_irq ? irq : tof) !== e)
      fail("pin level");
  endtask
  task automatic chk_read(input logic [63:0] note);
    n_checks++;
    if ((hrdata & note[63:32]) !== (note[31:0] & note[63:32]))
      fail("read data");
  endtask
  // Read completions compared against the oldest note; hang limit
  always @(posedge hclk)
  begin
    cyc++;
    if (pend && hreadyout)
      chk_read(exq.pop_front());
    pend <= (htrans[1] && hreadyout && !hwrite) || (pend && !hreadyout);
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`TFC_OFS_FFCR, 32'hc3, all);
    rd(`TFC_OFS_MODE, 32'h40, all);
    rd(`TFC_OFS_STATUS, 32'h0, all);
    for (int i = 0; i < 4; i++)
    begin
      wr(`TFC_OFS_FFCR, (32'hc9 >> (2 * i)) & 32'h3);
      chk(1'b0, 1'((4'b1101 >> i) & 1));
      rd(`TFC_OFS_FFCR, 32'hc3, all);
    end
    rv = xs(32'h3bf73792);
    wr(`TFC_OFS_FFCR, rv | 32'h3);
    chk(1'b0, 1'b1);
    rd(`TFC_OFS_FFCR, 32'hc3 | (rv & 32'h3c), all);
    wr(`TFC_OFS_COUNT, rv & 32'hffff);
    wr(`TFC_OFS_FFCR, 32'h13);
    wr(`TFC_OFS_MODE, 32'h1);
    chk(1'b0, 1'b0);
    rd(`TFC_OFS_MODE, 32'h41, all);
    rd(`TFC_OFS_CAP0, rv & 32'hffff, all);
    wr(`TFC_OFS_COUNT, ~rv & 32'hffff);
    wr(`TFC_OFS_MODE, 32'h41);
    chk(1'b0, 1'b0);
    rd(`TFC_OFS_CAP0, rv & 32'hffff, all);
    wr(`TFC_OFS_FFCR, 32'h23);
    cap_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    cap_pin <= 1'b0;
    chk(1'b0, 1'b1);
    rd(`TFC_OFS_CAP1, ~rv & 32'hffff, all);
    wr(`TFC_OFS_FFCR, 32'h3);
    wr(`TFC_OFS_COUNT, 32'h0);
    wr(`TFC_OFS_MODE, 32'h49);
    run(20);
    rd(`TFC_OFS_COUNT, 32'h0, all);
    chk(1'b1, 1'b0);
    rd(`TFC_OFS_STATUS, 32'h3, all);
    rd(`TFC_OFS_STATUS, 32'h0, all);
    wr(`TFC_OFS_MASK, 32'h4);
    wr(`TFC_OFS_CMP1, 32'h2);
    wr(`TFC_OFS_FFCR, 32'h7);
    wr(`TFC_OFS_COUNT, 32'hfff0);
    wr(`TFC_OFS_MODE, 32'h41);
    run(20);
    chk(1'b1, 1'b1);
    chk(1'b0, 1'b0);
    rd(`TFC_OFS_STATUS, 32'h7, all);
    chk(1'b1, 1'b0);
    wr(`TFC_OFS_FFCR, 32'ha);
    chk(1'b0, 1'b0);
    wr(`TFC_OFS_COUNT, 32'h0);
    wr(`TFC_OFS_MODE, 32'h41);
    run(20);
    chk(1'b0, 1'b1);
    wr(`TFC_OFS_COUNT, 32'h0);
    wr(`TFC_OFS_MODE, 32'h40);
    wr(`TFC_OFS_RUN, 32'h1);
    repeat (5)
    begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    wr(`TFC_OFS_RUN, 32'h0);
    rd(`TFC_OFS_COUNT, 32'h5, all);
    for (int c = 1; c < 8; c++)
    begin
      dv = c == 1 ? 1 : c == 2 ? 4 : 16 << (c - 3);
      wr(`TFC_OFS_COUNT, 32'h0);
      wr(`TFC_OFS_MODE, 32'h40 | c);
      run(528);
      rd(`TFC_OFS_COUNT, 528 / dv, dv < 16 ? ~(16 / dv - 1) : 32'hffff);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
